// File: src/aots_cfg.svh
// Configuration constants for the axis overtravel and scaling supervisor
`ifndef AOTS_CFG_SVH
`define AOTS_CFG_SVH
`define AOTS_CLK_HZ          100000000
`define AOTS_SAMPLE_MS       10
`define AOTS_SAMPLE_CYC      ((`AOTS_CLK_HZ / 1000) * `AOTS_SAMPLE_MS)
`define AOTS_SCALE_MIN       16'h0001
`define AOTS_SCALE_MAX       16'hffff
`define AOTS_RATIO_UP        8
`define AOTS_RATIO_DN        32
`define AOTS_FAULT_NONE      8'h00
`define AOTS_FAULT_SW_A      8'h21
`define AOTS_FAULT_SW_B      8'h22
`define AOTS_FAULT_SCALE     8'h23
`define AOTS_ADDR_CTRL       12'h000
`define AOTS_ADDR_SCALE      12'h004
`define AOTS_ADDR_STATUS     12'h008
`define AOTS_ADDR_IRQ_STAT   12'h00c
`define AOTS_ADDR_IRQ_CLR    12'h010
`define AOTS_ADDR_IRQ_EN     12'h014
`define AOTS_ADDR_VEL        12'h018
`define AOTS_CTRL_AMP_ON     0
`define AOTS_CTRL_OT_EN      1
`define AOTS_CTRL_JOG        2
`define AOTS_CTRL_ACK        3
`define AOTS_CTRL_MOVE       4
`define AOTS_SCALE_RESET     32'h0001_0001
`define AOTS_IRQ_TRIP_A      0
`define AOTS_IRQ_TRIP_B      1
`define AOTS_IRQ_SCALE_ERR   2
`define AOTS_IRQ_CLEARED     3
`endif

// File: src/aots_pkg.sv
// Types shared by the axis overtravel and scaling supervisor
`default_nettype none
package aots_pkg;
  typedef enum logic [2:0] {
    AOTS_RUN   = 3'b001,
    AOTS_TRIP  = 3'b010,
    AOTS_JOGOFF = 3'b100
  } aots_state_t;
endpackage
`default_nettype wire

// File: src/aots_if.sv
// Interface carrying the scaling pair to and from its checker
`default_nettype none
interface aots_scale_if;
  logic [15:0] user_units;
  logic [15:0] counts;
  logic        valid;
  modport chk (input user_units, input counts, output valid);
  modport top (output user_units, output counts, input valid);
endinterface
`default_nettype wire

// File: src/aots_scale_chk.sv
// Range and ratio checker for the user-unit to count scaling pair
`include "aots_cfg.svh"
`default_nettype none
module aots_scale_chk (
  input  wire logic  i_clk,    // System clock
  input  wire logic  i_resetn, // Async reset, active low
  aots_scale_if.chk  sc        // Scaling pair and verdict
);
  logic [20:0] uu_x32;
  logic        in_range;
  logic        ratio_ok;

  // Integer products only, no division
  assign uu_x32 = {sc.user_units, 5'h00};
  assign in_range = (sc.user_units >= `AOTS_SCALE_MIN) && (sc.counts >= `AOTS_SCALE_MIN)
                    && (sc.user_units <= `AOTS_SCALE_MAX) && (sc.counts <= `AOTS_SCALE_MAX);
  assign ratio_ok = ({4'h0, sc.user_units} <= {1'b0, sc.counts, 3'h0})
                    && (uu_x32 >= {5'h00, sc.counts});
  // Registered verdict
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sc.valid <= 1'b1;
    end else begin
      sc.valid <= in_range && ratio_ok;
    end
  end
endmodule
`default_nettype wire

// File: src/aots_top.sv
// Axis overtravel supervisor and scaling validator with AHB-Lite registers
// What this block does
// - Each scaling value must lie in 1..65535; others are rejected.
// - User units to counts ratio must lie in 8:1..1:32; others rejected.
// - Scaling is held as two integers forming an exact ratio.
// - Supervision off: switch inputs become program flow flags.
// - Supervision on: sample both switches every 10 ms while amplifier is on.
// - A low switch forces velocity command to zero at once, no ramp.
// - After a trip the enable relay stays closed until amplifier-on clears.
// - A trip reports a fault number naming the opened switch.
// - During a fault only jog together with acknowledge is accepted.
// - Once the fault clears, normal commands are accepted again.
//
// Design decisions made here: the address map and the AHB-Lite slave port.
`include "aots_cfg.svh"
`default_nettype none
module aots_top #(
  parameter int unsigned SAMPLE_CYC = `AOTS_SAMPLE_CYC // Cycles per 10 ms sample
) (
  input  wire logic        i_clk,          // 100 MHz clock
  input  wire logic        i_resetn,       // Async reset, active low
  input  wire logic        i_hsel,         // AHB select
  input  wire logic [31:0] i_haddr,        // AHB address
  input  wire logic [1:0]  i_htrans,       // AHB transfer type
  input  wire logic        i_hwrite,       // AHB write
  input  wire logic [2:0]  i_hsize,        // AHB size
  input  wire logic [31:0] i_hwdata,       // AHB write data
  input  wire logic        i_hready,       // AHB bus ready
  output logic      [31:0] o_hrdata,       // AHB read data
  output logic             o_hreadyout,    // AHB slave ready
  output logic             o_hresp,        // AHB response, always OKAY
  input  wire logic        i_travel_switch_input_a, // Limit switch A, low = open
  input  wire logic        i_travel_switch_input_b, // Limit switch B, low = open
  output logic      [1:0]  o_program_flow_flags,    // Switches as flow flags
  output logic      [15:0] o_velocity_cmd, // Servo velocity command
  output logic             o_enable_relay, // Axis enable relay closed
  output logic      [7:0]  o_fault_number, // Axis fault number
  output logic             o_irq           // Level interrupt
);
  localparam int unsigned CW = $clog2(SAMPLE_CYC + 1);

  // Switch synchronisers
  logic [1:0] sw_meta_q;
  logic [1:0] sw_sync_q;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sw_meta_q <= 2'h3;
      sw_sync_q <= 2'h3;
    end else begin
      sw_meta_q <= {i_travel_switch_input_b, i_travel_switch_input_a};
      sw_sync_q <= sw_meta_q;
    end
  end

  // AHB address phase capture
  logic        wr_pend_q;
  logic [11:0] addr_q;
  logic        rd_req;
  logic        wr_req;
  assign wr_req = i_hsel && i_hready && i_htrans[1] && i_hwrite;
  assign rd_req = i_hsel && i_hready && i_htrans[1] && !i_hwrite;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_pend_q <= 1'b0;
      addr_q    <= 12'h000;
    end else begin
      wr_pend_q <= wr_req;
      if (wr_req || rd_req) begin
        addr_q <= i_haddr[11:0];
      end
    end
  end

  // Slave is always ready with OKAY
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end else begin
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end
  end

  // Data phase write strobes, one per writable register
  logic wr_ctrl;
  logic wr_scale;
  logic wr_clr;
  logic wr_en;
  logic wr_vel;
  assign wr_ctrl  = wr_pend_q && (addr_q == `AOTS_ADDR_CTRL);
  assign wr_scale = wr_pend_q && (addr_q == `AOTS_ADDR_SCALE);
  assign wr_clr   = wr_pend_q && (addr_q == `AOTS_ADDR_IRQ_CLR);
  assign wr_en    = wr_pend_q && (addr_q == `AOTS_ADDR_IRQ_EN);
  assign wr_vel   = wr_pend_q && (addr_q == `AOTS_ADDR_VEL);

  // Host command bits
  logic [4:0] ctrl_q;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl_q <= 5'h00;
    end else if (wr_ctrl) begin
      ctrl_q <= i_hwdata[4:0];
    end
  end
  // Command bit fields
  logic amp_on;
  logic ot_en;
  logic jog_req;
  logic ack_req;
  logic move_req;
  assign amp_on   = ctrl_q[`AOTS_CTRL_AMP_ON];
  assign ot_en    = ctrl_q[`AOTS_CTRL_OT_EN];
  assign jog_req  = ctrl_q[`AOTS_CTRL_JOG];
  assign ack_req  = ctrl_q[`AOTS_CTRL_ACK];
  assign move_req = ctrl_q[`AOTS_CTRL_MOVE];

  // Requested velocity from host
  logic [15:0] vel_req_q;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      vel_req_q <= 16'h0000;
    end else if (wr_vel) begin
      vel_req_q <= i_hwdata[15:0];
    end
  end

  // Scaling pair: candidate, checked, then committed as integers
  aots_scale_if sc ();
  logic [31:0] scale_cand_q;
  logic [31:0] scale_q;
  logic        chk_pend_q;
  logic        chk_wait_q;
  logic        scale_err_ev;
  assign sc.user_units = scale_cand_q[31:16];
  assign sc.counts     = scale_cand_q[15:0];
  aots_scale_chk u_chk (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .sc       (sc)
  );

  // Check pipeline: write, then registered verdict two cycles later
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      chk_pend_q <= 1'b0;
      chk_wait_q <= 1'b0;
    end else begin
      chk_pend_q <= wr_scale;
      chk_wait_q <= chk_pend_q;
    end
  end

  // Candidate pair, taken whole so no partial ratio is ever applied
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      scale_cand_q <= `AOTS_SCALE_RESET;
    end else if (wr_scale) begin
      scale_cand_q <= i_hwdata;
    end
  end

  // Committed pair changes only on an accepting verdict
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      scale_q <= `AOTS_SCALE_RESET;
    end else if (chk_wait_q && sc.valid) begin
      scale_q <= scale_cand_q;
    end
  end

  // A rejecting verdict is a one-cycle event
  assign scale_err_ev = chk_wait_q && !sc.valid;

  // 10 ms sample tick, runs only while supervising
  logic [CW-1:0] tick_cnt_q;
  logic          tick_q;
  logic          supervise;
  assign supervise = ot_en && amp_on;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else if (!supervise) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q == CW'(SAMPLE_CYC - 1)) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
      tick_q     <= 1'b0;
    end
  end

  // Flow flags follow the switches only while overtravel enable is off
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_program_flow_flags <= 2'h0;
    end else begin
      o_program_flow_flags <= ot_en ? 2'h0 : sw_sync_q;
    end
  end

  // Fault state machine
  aots_pkg::aots_state_t state_q;
  logic trip_a;
  logic trip_b;
  logic cleared_ev;
  logic [1:0] trip;

  // One trip detector per switch, looked at only on the sample tick
  for (genvar g = 0; g < 2; g++) begin : g_trip
    assign trip[g] = supervise && tick_q && !sw_sync_q[g];
  end
  assign trip_a = trip[0];
  assign trip_b = trip[1];

  // Ack released after the jog off ends the fault
  assign cleared_ev = (state_q == aots_pkg::AOTS_JOGOFF) && !ack_req;

  // Next state; a trip is only taken from run
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= aots_pkg::AOTS_RUN;
    end else begin
      case (state_q)
        aots_pkg::AOTS_RUN: begin
          if (trip_a || trip_b) begin
            state_q <= aots_pkg::AOTS_TRIP;
          end
        end
        aots_pkg::AOTS_TRIP: begin
          if (jog_req && ack_req) begin
            state_q <= aots_pkg::AOTS_JOGOFF;
          end
        end
        aots_pkg::AOTS_JOGOFF: begin
          if (!ack_req) begin
            state_q <= aots_pkg::AOTS_RUN;
          end
        end
        default: begin
          state_q <= aots_pkg::AOTS_RUN;
        end
      endcase
    end
  end

  // Fault number names the opened switch, A takes priority
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_fault_number <= `AOTS_FAULT_NONE;
    end else if (state_q == aots_pkg::AOTS_RUN && trip_a) begin
      o_fault_number <= `AOTS_FAULT_SW_A;
    end else if (state_q == aots_pkg::AOTS_RUN && trip_b) begin
      o_fault_number <= `AOTS_FAULT_SW_B;
    end else if (cleared_ev) begin
      o_fault_number <= `AOTS_FAULT_NONE;
    end else if (scale_err_ev && state_q == aots_pkg::AOTS_RUN) begin
      o_fault_number <= `AOTS_FAULT_SCALE;
    end
  end

  // Velocity command: zero on trip, move or jog in run, jog with ack while jogging off
  logic run_ok;
  logic jog_ok;
  assign run_ok = (state_q == aots_pkg::AOTS_RUN) && !trip_a && !trip_b
                  && amp_on && (move_req || jog_req);
  assign jog_ok = (state_q == aots_pkg::AOTS_JOGOFF) && jog_req && ack_req && amp_on;

  // Registered command, zero whenever motion is not allowed
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_velocity_cmd <= 16'h0000;
    end else if (run_ok || jog_ok) begin
      o_velocity_cmd <= vel_req_q;
    end else begin
      o_velocity_cmd <= 16'h0000;
    end
  end

  // Relay follows the amplifier-on request, trips do not open it
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_enable_relay <= 1'b0;
    end else begin
      o_enable_relay <= amp_on;
    end
  end

  // Events in status bit order
  logic [3:0] irq_stat_q;
  logic [3:0] irq_en_q;
  logic [3:0] ev;
  assign ev[`AOTS_IRQ_TRIP_A]    = trip_a && (state_q == aots_pkg::AOTS_RUN);
  assign ev[`AOTS_IRQ_TRIP_B]    = trip_b && (state_q == aots_pkg::AOTS_RUN);
  assign ev[`AOTS_IRQ_SCALE_ERR] = scale_err_ev;
  assign ev[`AOTS_IRQ_CLEARED]   = cleared_ev;

  // Sticky status bits, a set in the same cycle as its clear wins
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_stat_q <= 4'h0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~(wr_clr ? i_hwdata[3:0] : 4'h0)) | ev;
    end
  end

  // Interrupt enable mask
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_en_q <= 4'h0;
    end else if (wr_en) begin
      irq_en_q <= i_hwdata[3:0];
    end
  end

  // Level interrupt while any enabled status bit is set
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(irq_stat_q & irq_en_q);
    end
  end

  // Read data is registered in the address phase
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_hrdata <= 32'h0000_0000;
    end else if (rd_req) begin
      case (i_haddr[11:0])
        `AOTS_ADDR_CTRL:     o_hrdata <= {27'h0, ctrl_q};
        `AOTS_ADDR_SCALE:    o_hrdata <= scale_q;
        `AOTS_ADDR_STATUS:   o_hrdata <= {16'h0, o_fault_number, 1'b0, state_q,
                                          o_enable_relay, sw_sync_q, supervise};
        `AOTS_ADDR_IRQ_STAT: o_hrdata <= {28'h0, irq_stat_q};
        `AOTS_ADDR_IRQ_EN:   o_hrdata <= {28'h0, irq_en_q};
        `AOTS_ADDR_VEL:      o_hrdata <= {16'h0, vel_req_q};
        default:             o_hrdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: sim/aots_top_monitor.sv
// Port checker for the axis overtravel supervisor
`default_nettype none
module aots_top_monitor #(
  parameter int unsigned SAMPLE_CYC = 20 // Cycles per sample tick
) (
  input wire logic        i_clk,                   // Clock
  input wire logic        i_resetn,                // Reset, active low
  input wire logic        i_travel_switch_input_a, // Switch A, low = open
  input wire logic        i_travel_switch_input_b, // Switch B, low = open
  input wire logic        o_hreadyout,             // Slave ready
  input wire logic        o_hresp,                 // Slave response
  input wire logic [1:0]  o_program_flow_flags,    // Flow flags
  input wire logic [15:0] o_velocity_cmd,          // Velocity command
  input wire logic        o_enable_relay,          // Relay closed
  input wire logic [7:0]  o_fault_number           // Fault number
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // Fault numbers naming each tripped switch
  logic trip_a;
  logic trip_b;
  assign trip_a = (o_fault_number == 8'h21);
  assign trip_b = (o_fault_number == 8'h22);
  AST_BUS_OKAY: assert property (o_hreadyout && !o_hresp)
    else $error("bus slave not ready or not okay");
  AST_TRIP_A_STOP: assert property ($rose(trip_a) |-> o_velocity_cmd == 16'h0)
    else $error("velocity not zero on trip of switch A");
  AST_TRIP_B_STOP: assert property ($rose(trip_b) |-> o_velocity_cmd == 16'h0)
    else $error("velocity not zero on trip of switch B");
  AST_TRIP_A_CAUSE: assert property ($rose(trip_a) |-> !$past(i_travel_switch_input_a, 3))
    else $error("switch A fault without switch A open");
  AST_TRIP_B_CAUSE: assert property ($rose(trip_b) |-> !$past(i_travel_switch_input_b, 3))
    else $error("switch B fault without switch B open");
  AST_TRIP_RELAY: assert property ($rose(trip_a || trip_b) |->
      o_enable_relay && $past(o_enable_relay)) else $error("relay open at trip");
  AST_TRIP_HOLD: assert property ($rose(trip_a || trip_b) |->
      (o_velocity_cmd == 16'h0) [*2]) else $error("motion right after trip");
  AST_FLAGS_QUIET: assert property ($rose(trip_a || trip_b) |->
      $past(o_program_flow_flags) == 2'h0) else $error("flow flags live while supervised");
  AST_FLAG_A_SRC: assert property (o_program_flow_flags[0] |->
      $past(i_travel_switch_input_a, 2) || $past(i_travel_switch_input_a, 3) ||
      $past(i_travel_switch_input_a, 4)) else $error("flag A without switch A closed");
endmodule
bind aots_top aots_top_monitor #(.SAMPLE_CYC(SAMPLE_CYC)) u_mon (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_travel_switch_input_a(i_travel_switch_input_a),
  .i_travel_switch_input_b(i_travel_switch_input_b), .o_hreadyout(o_hreadyout),
  .o_hresp(o_hresp), .o_program_flow_flags(o_program_flow_flags),
  .o_velocity_cmd(o_velocity_cmd), .o_enable_relay(o_enable_relay),
  .o_fault_number(o_fault_number));
`default_nettype wire

// File: sim/aots_field_model.sv
// Field side model: two normally closed limit switches
`default_nettype none
module aots_field_model (
  input  wire logic i_open_a, // Switch A pushed open
  input  wire logic i_open_b, // Switch B pushed open
  output logic      o_sw_a,   // Switch A line, low when open
  output logic      o_sw_b    // Switch B line, low when open
);
  timeunit 1ns;
  timeprecision 1ps;
  // A closed switch holds its line high; opening it pulls the line low
  assign o_sw_a = !i_open_a;
  assign o_sw_b = !i_open_b;
endmodule
`default_nettype wire

// File: sim/test_axis_overtravel_and_scaling.sv
// Self-checking bench for the axis overtravel supervisor
`default_nettype none
module test_axis_overtravel_and_scaling;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned SCYC = 20; // Shortened sample tick
  logic        i_clk    = 1'b0;
  logic        i_resetn = 1'b0;
  logic        hsel     = 1'b0;
  logic [31:0] haddr    = 32'h0;
  logic [1:0]  htrans   = 2'h0;
  logic        hwrite   = 1'b0;
  logic [31:0] hwdata   = 32'h0;
  logic        rd_ph    = 1'b0;
  logic        open_a   = 1'b0;
  logic        open_b   = 1'b0;
  logic [31:0] scale_q  = 32'h0001_0001;
  logic [15:0] uu_t [9] = '{16'h1, 16'h8, 16'h9, 16'h1, 16'h1, 16'hffff, 16'h0, 16'h5, 16'h1198};
  logic [15:0] cn_t [9] = '{16'h1, 16'h1, 16'h1, 16'h20, 16'h21, 16'hffff, 16'h5, 16'h0, 16'h3e80};
  logic [15:0] uu;
  logic [15:0] cn;
  logic [15:0] vel;
  logic        ok;
  logic [31:0] exp_q [$];
  int          error_cnt  = 0;
  int          n_compared = 0;
  wire logic        sw_a;
  wire logic        sw_b;
  wire logic [31:0] hrdata;
  wire logic        hready;
  wire logic [1:0]  flags;
  wire logic [15:0] vel_o;
  wire logic        relay;
  wire logic [7:0]  fault;
  wire logic        irq;
  aots_field_model u_field (.i_open_a(open_a), .i_open_b(open_b), .o_sw_a(sw_a), .o_sw_b(sw_b));
  aots_top #(.SAMPLE_CYC(SCYC)) uut (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
    .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(), .i_travel_switch_input_a(sw_a),
    .i_travel_switch_input_b(sw_b), .o_program_flow_flags(flags), .o_velocity_cmd(vel_o),
    .o_enable_relay(relay), .o_fault_number(fault), .o_irq(irq));
  // Free running 100 MHz clock
  initial begin
    forever #5 i_clk = ~i_clk;
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    if (error_cnt == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // One single word transfer; each phase held until ready is sampled high
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge i_clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge i_clk);
    while (!hready) @(posedge i_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_ph <= !w;
    @(posedge i_clk);
    while (!hready) @(posedge i_clk);
    rd_ph <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(a, 1'b0, 32'h0);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic set_sw(input int s, input logic v);
    @(posedge i_clk);
    if (s == 0) open_a <= v;
    else open_b <= v;
  endtask
  // Each completed read is matched against the oldest noted value
  always @(posedge i_clk) begin
    if (rd_ph && hready) cmp(hrdata, exp_q.pop_front());
  end
  // Hang guard, far beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge i_clk);
    error_cnt++;
    print_verdict;
  end
  initial begin
    void'($urandom(43529));
    repeat (12) @(posedge i_clk);
    i_resetn <= 1'b1;
    rd(32'h4, 32'h0001_0001);
    rd(32'h1c, 32'h0);
    wr(32'h14, 32'hf);
    // Random pairs, then the range and ratio edges
    for (int i = 0; i < 12; i++) begin
      uu = (i < 3) ? 16'($urandom_range(1, 65535)) : uu_t[i-3];
      cn = (i < 3) ? 16'($urandom_range(1, 65535)) : cn_t[i-3];
      ok = uu != 0 && cn != 0 && uu <= 8 * cn && 32 * uu >= cn;
      wr(32'h4, {uu, cn});
      cyc(3);
      if (ok) scale_q = {uu, cn};
      rd(32'h4, scale_q);
      rd(32'hc, {29'h0, !ok, 2'h0});
      wr(32'h10, 32'hf);
    end
    // Per switch: flow flag, trip, refused move, jog off with ack, recovery
    for (int s = 0; s < 2; s++) begin
      vel = 16'($urandom_range(1, 65535));
      wr(32'h18, {16'h0, vel});
      wr(32'h0, 32'h1);
      set_sw(s, 1'b1);
      cyc(6);
      cmp(flags, s ? 2'h1 : 2'h2);
      set_sw(s, 1'b0);
      wr(32'h0, 32'h13);
      cyc(4);
      cmp(vel_o, vel);
      set_sw(s, 1'b1);
      cyc(SCYC + 8);
      cmp(vel_o, 16'h0);
      cmp(fault, 8'h21 + 8'(s));
      cmp(relay, 1'b1);
      cmp(flags, 2'h0);
      cmp(irq, 1'b1);
      wr(32'h0, 32'h17);
      cyc(3);
      cmp(vel_o, 16'h0);
      wr(32'h0, 32'hf); // Ack held through the whole jog
      set_sw(s, 1'b0);
      cyc(3);
      cmp(vel_o, vel);
      wr(32'h0, 32'h13);
      cyc(3);
      cmp(fault, 8'h0);
      cmp(vel_o, vel);
      rd(32'hc, (32'h1 << s) | 32'h8);
      wr(32'h10, 32'hf);
      cyc(3);
      cmp(irq, 1'b0);
      wr(32'h0, 32'h0);
      cyc(2);
      cmp(relay, 1'b0);
    end
    print_verdict;
  end
endmodule
`default_nettype wire
